/* core/adc_alert_defs.svh */
// Constants of the threshold alert block: register map, fields, resets, timing.
// Included by the phy, the alert logic and the bench; holds definitions only.
`ifndef ADC_ALERT_DEFS_SVH
`define ADC_ALERT_DEFS_SVH

// Register pointer codes
`define PTR_CONV 2'h0
`define PTR_CFG 2'h1
`define PTR_LOW 2'h2
`define PTR_HIGH 2'h3

// Reset values
`define CFG_RESET 16'h8583
`define LOW_LIMIT_RESET 16'h8000
`define HIGH_LIMIT_RESET 16'h7fff

// Configuration field positions
`define CFG_OS 15
`define CFG_MODE 8
`define CFG_CMODE 4
`define CFG_POL 3
`define CFG_LAT 2
`define CFG_QUE_HI 1
`define CFG_QUE_LO 0
`define SIGN_BIT 15

// Queue codes and depths
`define QUE_ONE 2'h0
`define QUE_TWO 2'h1
`define QUE_OFF 2'h3
`define NEED_ONE 3'h1
`define NEED_TWO 3'h2
`define NEED_FOUR 3'h4

// Bus addressing
`define ADDR_BASE 5'h12
`define ARA_ADDR 7'h0c

// Bit engine counts
`define BIT_LAST 4'h7
`define BIT_ACK 4'h8

// Timing
`define CLK_PERIOD_NS 100
`define RDY_PULSE_NS 800
`define RDY_PULSE_CYC (4'(`RDY_PULSE_NS / `CLK_PERIOD_NS))

`endif

/* core/adc_alert_pkg.sv */
// Types of the threshold alert block.
// Constants live in adc_alert_defs.svh.
package adc_alert_pkg;

  typedef enum logic [7:0] {
    st_idle  = 8'h01,
    st_addr  = 8'h02,
    st_ptr   = 8'h04,
    st_wr_hi = 8'h08,
    st_wr_lo = 8'h10,
    st_rd_hi = 8'h20,
    st_rd_lo = 8'h40,
    st_ara   = 8'h80
  } bus_state_t;

endpackage : adc_alert_pkg

/* core/twowire_slave_phy.sv */
// Two-wire slave bit engine: pin synchronisers, start/stop, byte shift, ack.
// Assumes scl/sda asynchronous to ref_clk_i; this slave never drives scl.
`timescale 1ns/1ps
`include "adc_alert_defs.svh"
module twowire_slave_phy (
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_o,
  // Byte side
  input wire logic ack_i,
  input wire logic tx_mode_i,
  input wire logic [7:0] tx_byte_i,
  output logic start_o,
  output logic stop_o,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o,
  output logic tx_done_o,
  output logic tx_nack_o,
  output logic arb_lost_o
);

  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_q_reg;
  logic sda_q_reg;
  logic scl_s;
  logic sda_s;
  logic rise;
  logic fall;
  logic active_reg;
  logic tx_dir_reg;
  logic drive_reg;
  logic ack_pend_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, sampling only: scl is never driven
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else if (clk_en_i) begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      scl_q_reg <= scl_sync_reg[1];
      sda_q_reg <= sda_sync_reg[1];
    end
  end

  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];
  assign rise = scl_s & ~scl_q_reg;
  assign fall = ~scl_s & scl_q_reg;
  assign start_o = clk_en_i & scl_s & scl_q_reg & sda_q_reg & ~sda_s;
  assign stop_o = clk_en_i & scl_s & scl_q_reg & ~sda_q_reg & sda_s;
  assign rx_valid_o = clk_en_i & active_reg & fall & ~tx_dir_reg &
                      (bit_cnt_reg == `BIT_LAST);
  assign rx_byte_o = shift_reg;
  assign tx_done_o = clk_en_i & active_reg & rise & tx_dir_reg &
                     (bit_cnt_reg == `BIT_ACK);
  assign tx_nack_o = sda_s;
  assign arb_lost_o = clk_en_i & active_reg & rise & tx_dir_reg & tx_reg[7] &
                      ~sda_s & (bit_cnt_reg != `BIT_ACK);
  assign sda_oe_o = drive_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      active_reg <= 1'b0;
      tx_dir_reg <= 1'b0;
      drive_reg <= 1'b0;
      ack_pend_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
    end else if (clk_en_i) begin
      ack_pend_reg <= 1'b0;
      if (start_o) begin
        active_reg <= 1'b1;
        tx_dir_reg <= 1'b0;
        drive_reg <= 1'b0;
        // First clock fall after start only opens bit 7
        bit_cnt_reg <= `BIT_ACK;
      end else if (stop_o) begin
        active_reg <= 1'b0;
        drive_reg <= 1'b0;
      end else if (active_reg) begin
        if (ack_pend_reg) begin
          drive_reg <= ack_i;
        end
        if (rise && bit_cnt_reg != `BIT_ACK) begin
          shift_reg <= {shift_reg[6:0], sda_s};
          if (arb_lost_o) begin
            active_reg <= 1'b0;
            drive_reg <= 1'b0;
          end
        end else if (fall) begin
          if (bit_cnt_reg == `BIT_ACK) begin
            bit_cnt_reg <= 4'h0;
            tx_dir_reg <= tx_mode_i;
            tx_reg <= tx_byte_i;
            drive_reg <= tx_mode_i & ~tx_byte_i[7];
          end else if (bit_cnt_reg == `BIT_LAST) begin
            bit_cnt_reg <= `BIT_ACK;
            drive_reg <= 1'b0;
            ack_pend_reg <= ~tx_dir_reg;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            tx_reg <= {tx_reg[6:0], 1'b0};
            drive_reg <= tx_dir_reg & ~tx_reg[6];
          end
        end
      end
    end
  end

endmodule : twowire_slave_phy

/* core/adc_threshold_alert_logic.sv */
// Threshold comparator, alert/ready pin and two-wire register slave.
// Assumes the converter core runs on ref_clk_i and pulses conv_done_i per result.
//
// Overview of operation
// - Queue code 11 disables the comparator and holds the pin high; default.
// - Queue codes 00, 01, 10 need one, two, four successive out-of-range results.
// - Low and high limits are separate 16-bit two's-complement registers.
// - High limit MSB 1 with low limit MSB 0 selects conversion-ready use.
// - Ready use in single-shot mode drives the pin with the status bit.
// - Ready use in continuous mode pulses the pin per finished conversion.
// - Low limit resets to 8000h.
// - High limit resets to 7fffh.
// - The slave never pulls the clock line low.
// - Works with standard, fast and high-speed, master-only bus controllers.
// - One of four slave addresses, picked by the address select pin.
// - The two low address bits come from the address select pin.
// - Comparator mode bit selects hysteresis comparator (0) or window comparator (1).
// - Polarity bit makes the pin active low (0) or active high (1).
// - Latched alert holds until data read or alert response won and acked by the master.
// - Status bit reads 1 when idle, 0 while converting.
`timescale 1ns/1ps
`include "adc_alert_defs.svh"
module adc_threshold_alert_logic (
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Two-wire bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Address select strap
  input wire logic [1:0] addr_sel_i,
  // Converter core
  input wire logic conv_done_i,
  input wire logic [15:0] conv_data_i,
  input wire logic conv_busy_i,
  output logic conv_start_o,
  output logic [15:0] config_o,
  // Alert / ready pin
  output logic alert_rdy_o
);

  logic [1:0] addr_meta_reg;
  logic [1:0] addr_sync_reg;
  logic [6:0] own_addr;
  logic bus_start;
  logic bus_stop;
  logic rx_valid;
  logic tx_done;
  logic tx_nack;
  logic arb_lost;
  logic [7:0] rx_byte;
  adc_alert_pkg::bus_state_t state_reg;
  logic ack_reg;
  logic tx_mode_reg;
  logic [7:0] tx_byte_reg;
  logic [7:0] rd_lo_reg;
  logic [7:0] wr_hi_reg;
  logic [1:0] ptr_reg;
  logic [15:0] cfg_reg;
  logic [15:0] conv_reg;
  logic [15:0] low_limit_value_reg;
  logic [15:0] high_limit_value_reg;
  logic [15:0] rd_word;
  logic [15:0] wr_word;
  logic wr_strobe;
  logic os_reg;
  logic conv_start_reg;
  logic [1:0] que;
  logic single_mode;
  logic pol_bit;
  logic lat_bit;
  logic win_bit;
  logic rdy_mode;
  logic above;
  logic below;
  logic out_rng;
  logic clear_ok;
  logic clr_latch;
  logic [2:0] need;
  logic [2:0] oor_cnt_reg;
  logic alert_act_reg;
  logic pin_reg;
  logic [3:0] pulse_cnt_reg;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // Address strap and bit engine
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      addr_meta_reg <= 2'h0;
      addr_sync_reg <= 2'h0;
    end else if (clk_en_i) begin
      addr_meta_reg <= addr_sel_i;
      addr_sync_reg <= addr_meta_reg;
    end
  end

  assign own_addr = {`ADDR_BASE, addr_sync_reg};

  twowire_slave_phy phy (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_oe_o(sda_oe_o),
    .ack_i(ack_reg),
    .tx_mode_i(tx_mode_reg),
    .tx_byte_i(tx_byte_reg),
    .start_o(bus_start),
    .stop_o(bus_stop),
    .rx_valid_o(rx_valid),
    .rx_byte_o(rx_byte),
    .tx_done_o(tx_done),
    .tx_nack_o(tx_nack),
    .arb_lost_o(arb_lost)
  );

  // Open-drain: only ever pulls low
  assign sda_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Transaction sequencer
  always_comb begin
    case (ptr_reg)
      `PTR_CONV: rd_word = conv_reg;
      `PTR_CFG: rd_word = {os_reg, cfg_reg[14:0]};
      `PTR_LOW: rd_word = low_limit_value_reg;
      default: rd_word = high_limit_value_reg;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= adc_alert_pkg::st_idle;
      ack_reg <= 1'b0;
      tx_mode_reg <= 1'b0;
      tx_byte_reg <= 8'h00;
      rd_lo_reg <= 8'h00;
      wr_hi_reg <= 8'h00;
      ptr_reg <= `PTR_CONV;
    end else if (clk_en_i) begin
      ack_reg <= 1'b0;
      if (bus_start) begin
        state_reg <= adc_alert_pkg::st_addr;
        tx_mode_reg <= 1'b0;
      end else if (bus_stop) begin
        state_reg <= adc_alert_pkg::st_idle;
        tx_mode_reg <= 1'b0;
      end else begin
        case (state_reg)
          adc_alert_pkg::st_addr: begin
            if (rx_valid && rx_byte[7:1] == own_addr) begin
              ack_reg <= 1'b1;
              if (rx_byte[0]) begin
                state_reg <= adc_alert_pkg::st_rd_hi;
                tx_mode_reg <= 1'b1;
                tx_byte_reg <= rd_word[15:8];
                rd_lo_reg <= rd_word[7:0];
              end else begin
                state_reg <= adc_alert_pkg::st_ptr;
              end
            end else if (rx_valid && rx_byte == {`ARA_ADDR, 1'b1} && alert_act_reg &&
                         !rdy_mode) begin
              ack_reg <= 1'b1;
              state_reg <= adc_alert_pkg::st_ara;
              tx_mode_reg <= 1'b1;
              tx_byte_reg <= {own_addr, 1'b0};
            end else if (rx_valid) begin
              state_reg <= adc_alert_pkg::st_idle;
            end
          end
          adc_alert_pkg::st_ptr: begin
            if (rx_valid) begin
              ptr_reg <= rx_byte[1:0];
              ack_reg <= 1'b1;
              state_reg <= adc_alert_pkg::st_wr_hi;
            end
          end
          adc_alert_pkg::st_wr_hi: begin
            if (rx_valid) begin
              wr_hi_reg <= rx_byte;
              ack_reg <= 1'b1;
              state_reg <= adc_alert_pkg::st_wr_lo;
            end
          end
          adc_alert_pkg::st_wr_lo: begin
            if (rx_valid) begin
              ack_reg <= 1'b1;
              state_reg <= adc_alert_pkg::st_idle;
            end
          end
          adc_alert_pkg::st_rd_hi: begin
            if (tx_done && tx_nack) begin
              state_reg <= adc_alert_pkg::st_idle;
              tx_mode_reg <= 1'b0;
            end else if (tx_done) begin
              tx_byte_reg <= rd_lo_reg;
              state_reg <= adc_alert_pkg::st_rd_lo;
            end
          end
          adc_alert_pkg::st_rd_lo, adc_alert_pkg::st_ara: begin
            if (tx_done || arb_lost) begin
              state_reg <= adc_alert_pkg::st_idle;
              tx_mode_reg <= 1'b0;
            end
          end
          adc_alert_pkg::st_idle: begin
            tx_mode_reg <= 1'b0;
          end
          default: begin
            state_reg <= adc_alert_pkg::st_idle;
            tx_mode_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  assign wr_word = {wr_hi_reg, rx_byte};
  assign wr_strobe = rx_valid && state_reg == adc_alert_pkg::st_wr_lo;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_reg <= `CFG_RESET;
      low_limit_value_reg <= `LOW_LIMIT_RESET;
      high_limit_value_reg <= `HIGH_LIMIT_RESET;
      conv_start_reg <= 1'b0;
    end else if (clk_en_i) begin
      conv_start_reg <= 1'b0;
      if (wr_strobe) begin
        case (ptr_reg)
          `PTR_CFG: begin
            cfg_reg <= {cfg_reg[`CFG_OS], wr_word[14:0]};
            conv_start_reg <= wr_word[`CFG_OS] & single_mode & os_reg;
          end
          `PTR_LOW: low_limit_value_reg <= wr_word;
          `PTR_HIGH: high_limit_value_reg <= wr_word;
          default: ;
        endcase
      end
    end
  end

  // Status and result capture
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      os_reg <= 1'b1;
      conv_reg <= 16'h0000;
    end else if (clk_en_i) begin
      os_reg <= ~conv_busy_i;
      if (conv_done_i) begin
        conv_reg <= conv_data_i;
      end
    end
  end

  assign conv_start_o = conv_start_reg;
  assign config_o = cfg_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Digital comparator and queue
  assign que = cfg_reg[`CFG_QUE_HI:`CFG_QUE_LO];
  assign single_mode = cfg_reg[`CFG_MODE];
  assign pol_bit = cfg_reg[`CFG_POL];
  assign lat_bit = cfg_reg[`CFG_LAT];
  assign win_bit = cfg_reg[`CFG_CMODE];
  assign rdy_mode = high_limit_value_reg[`SIGN_BIT] &
                    ~low_limit_value_reg[`SIGN_BIT];
  assign above = $signed(conv_data_i) > $signed(high_limit_value_reg);
  assign below = $signed(conv_data_i) < $signed(low_limit_value_reg);
  assign out_rng = above | (win_bit & below);
  assign clear_ok = win_bit ? (~above & ~below) : below;
  assign clr_latch = clk_en_i & tx_done & ~tx_nack &
                     ((state_reg == adc_alert_pkg::st_rd_hi && ptr_reg == `PTR_CONV) ||
                      state_reg == adc_alert_pkg::st_ara);

  always_comb begin
    case (que)
      `QUE_ONE: need = `NEED_ONE;
      `QUE_TWO: need = `NEED_TWO;
      default: need = `NEED_FOUR;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      oor_cnt_reg <= 3'h0;
      alert_act_reg <= 1'b0;
    end else if (clk_en_i) begin
      if (que == `QUE_OFF) begin
        oor_cnt_reg <= 3'h0;
        alert_act_reg <= 1'b0;
      end else begin
        if (clr_latch && lat_bit) begin
          alert_act_reg <= 1'b0;
        end
        if (conv_done_i && out_rng) begin
          if (oor_cnt_reg != need) begin
            oor_cnt_reg <= oor_cnt_reg + 3'h1;
          end
          if (3'(oor_cnt_reg + 3'h1) >= need) begin
            alert_act_reg <= 1'b1;
          end
        end else if (conv_done_i) begin
          oor_cnt_reg <= 3'h0;
          if (!lat_bit && clear_ok) begin
            alert_act_reg <= 1'b0;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alert / ready pin
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pulse_cnt_reg <= 4'h0;
      pin_reg <= 1'b1;
    end else if (clk_en_i) begin
      if (conv_done_i && rdy_mode && !single_mode) begin
        pulse_cnt_reg <= `RDY_PULSE_CYC;
      end else if (pulse_cnt_reg != 4'h0) begin
        pulse_cnt_reg <= pulse_cnt_reg - 4'h1;
      end
      if (que == `QUE_OFF) begin
        pin_reg <= 1'b1;
      end else if (rdy_mode && single_mode) begin
        pin_reg <= os_reg;
      end else if (rdy_mode) begin
        pin_reg <= (pulse_cnt_reg != 4'h0) ? pol_bit : ~pol_bit;
      end else begin
        pin_reg <= alert_act_reg ? pol_bit : ~pol_bit;
      end
    end
  end

  assign alert_rdy_o = pin_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_que_off_high: assert property (
    clk_en_i && que == `QUE_OFF |=> alert_rdy_o)
    else $error("pin not high with comparator disabled");
  a_queue_depth: assert property (
    $rose(alert_act_reg) |-> $past(conv_done_i) &&
    (3'($past(oor_cnt_reg) + 3'h1) >= $past(need)))
    else $error("alert set before queue depth reached");
  a_limit_hold: assert property (
    clk_en_i && !wr_strobe |=> $stable(low_limit_value_reg) &&
    $stable(high_limit_value_reg))
    else $error("limit changed without a write");
  a_rdy_single: assert property (
    clk_en_i && rdy_mode && single_mode && que != `QUE_OFF |=>
    alert_rdy_o == $past(os_reg))
    else $error("ready pin does not follow status");
  a_rdy_pulse: assert property (
    clk_en_i && conv_done_i && rdy_mode && !single_mode && que != `QUE_OFF &&
    !wr_strobe ##1 clk_en_i && !wr_strobe |=> alert_rdy_o == $past(pol_bit))
    else $error("no ready pulse after conversion");
  a_addr_filter: assert property (
    clk_en_i && rx_valid && state_reg == adc_alert_pkg::st_addr &&
    rx_byte[7:1] != own_addr && rx_byte[7:1] != `ARA_ADDR |=> !ack_reg)
    else $error("foreign address acknowledged");
  a_window_clear: assert property (
    clk_en_i && conv_done_i && win_bit && !lat_bit && !above && !below &&
    que != `QUE_OFF |=> !alert_act_reg)
    else $error("window alert not cleared in range");
  a_pol_level: assert property (
    clk_en_i && que != `QUE_OFF && !rdy_mode |=>
    alert_rdy_o == ($past(alert_act_reg) == $past(pol_bit)))
    else $error("pin level disagrees with polarity");
  a_latch_hold: assert property (
    clk_en_i && alert_act_reg && lat_bit && !clr_latch && que != `QUE_OFF |=>
    alert_act_reg)
    else $error("latched alert dropped");
  a_os_track: assert property (
    clk_en_i |=> os_reg == !$past(conv_busy_i))
    else $error("status bit does not track busy");
  a_count_clear: assert property (
    clk_en_i && conv_done_i && !out_rng && que != `QUE_OFF |=> oor_cnt_reg == 3'h0)
    else $error("queue counter not cleared in range");

endmodule : adc_threshold_alert_logic

/* bench/twowire_host_model.sv */
// Two-wire bus host: start, stop and nine-bit transfer tasks.
// Assumes a pull-up on data; the device never drives the clock.
`timescale 1ns/1ps
module twowire_host_model (
  // Clock
  input wire logic ref_clk_i,
  // Bus
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // Each phase lasts four cycles
  task automatic step(input logic c, input logic d);
    @(posedge ref_clk_i);
    scl_o <= c;
    sda_low_o <= ~d;
    repeat (3) @(posedge ref_clk_i);
  endtask : step
  task automatic start_cond();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask : start_cond
  task automatic stop_cond();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask : stop_cond
  // Ninth bit: 0 acks, 1 releases (ends a read)
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                      output logic ack);
    logic [8:0] b;
    b = {tx, last};
    for (int i = 8; i >= 0; i--) begin
      step(1'b0, ~sda_low_o);
      step(1'b0, b[i]);
      step(1'b1, b[i]);
      if (i > 0) rx[i-1] = sda_i;
      else ack = ~sda_i;
    end
  endtask : xfer
endmodule : twowire_host_model

/* bench/adc_threshold_alert_logic_tb.sv */
// Self-checking bench of the threshold alert block.
// Assumes the host model drives the bus and a pull-up holds data high.
`timescale 1ns/1ps
`include "adc_alert_defs.svh"
module adc_threshold_alert_logic_tb;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [1:0] addr_sel_i = 2'h0;
  logic conv_done_i = 1'b0;
  logic [15:0] conv_data_i = 16'h0000;
  logic conv_busy_i = 1'b0;
  logic scl, host_low, sda_oe_o, alert_rdy_o, conv_start_o;
  logic start_seen = 1'b0;
  logic [15:0] config_o;
  wire sda_line = ~(host_low | sda_oe_o);
  int fail_count = 0;
  int checks = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (conv_start_o === 1'b1) start_seen <= 1'b1;
  adc_threshold_alert_logic dut_u (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1), .scl_i(scl),
    .sda_i(sda_line), .sda_o(), .sda_oe_o(sda_oe_o), .addr_sel_i(addr_sel_i),
    .conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .conv_busy_i(conv_busy_i),
    .conv_start_o(conv_start_o), .config_o(config_o), .alert_rdy_o(alert_rdy_o));
  twowire_host_model host_u (.ref_clk_i(ref_clk_i), .sda_i(sda_line), .scl_o(scl),
    .sda_low_o(host_low));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : chk
  task automatic put_ptr(input logic [1:0] ptr);
    logic [7:0] rx;
    logic ack;
    host_u.start_cond();
    host_u.xfer({`ADDR_BASE, addr_sel_i, 1'b0}, 1'b1, rx, ack);
    chk("address ack", 16'h0001, {15'h0, ack});
    host_u.xfer({6'h00, ptr}, 1'b1, rx, ack);
  endtask : put_ptr
  task automatic wr(input logic [1:0] ptr, input logic [15:0] v);
    logic [7:0] rx;
    logic ack;
    put_ptr(ptr);
    host_u.xfer(v[15:8], 1'b1, rx, ack);
    host_u.xfer(v[7:0], 1'b1, rx, ack);
    chk("write ack", 16'h0001, {15'h0, ack});
    host_u.stop_cond();
  endtask : wr
  task automatic rd(input logic [1:0] ptr, output logic [15:0] v);
    logic [7:0] rx;
    logic ack;
    put_ptr(ptr);
    host_u.stop_cond();
    host_u.start_cond();
    host_u.xfer({`ADDR_BASE, addr_sel_i, 1'b1}, 1'b1, rx, ack);
    host_u.xfer(8'hff, 1'b0, v[15:8], ack);
    host_u.xfer(8'hff, 1'b1, v[7:0], ack);
    host_u.stop_cond();
  endtask : rd
  task automatic conv(input logic [15:0] d);
    @(posedge ref_clk_i);
    conv_done_i <= 1'b1;
    conv_data_i <= d;
    @(posedge ref_clk_i);
    conv_done_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
  endtask : conv
  task automatic pin(input logic e);
    chk("alert pin", {15'h0, e}, {15'h0, alert_rdy_o});
  endtask : pin
  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [15:0] v;
    rd(`PTR_LOW, v);
    chk("low limit", 16'h8000, v);
    rd(`PTR_HIGH, v);
    chk("high limit", 16'h7fff, v);
    chk("config", 16'h8583, config_o);
    pin(1'b1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_queue();
    logic [15:0] v;
    logic [2:0] need [3] = '{`NEED_ONE, `NEED_TWO, `NEED_FOUR};
    wr(`PTR_LOW, 16'h0100);
    wr(`PTR_HIGH, 16'h0200);
    rd(`PTR_HIGH, v);
    chk("high limit", 16'h0200, v);
    for (int q = 0; q < 3; q++) begin
      wr(`PTR_CFG, 16'h0580 | 16'(q));
      repeat (2) begin
        for (int n = 1; n < need[q]; n++) conv(16'h0300);
        pin(1'b1);
        conv(16'h0150);
      end
      for (int n = 0; n < need[q]; n++) conv(16'h0300);
      pin(1'b0);
      conv(16'h0050);
      pin(1'b1);
    end
    wr(`PTR_CFG, 16'h0583);
    conv(16'h0300);
    pin(1'b1);
    $display("test queue done");
  endtask : t_queue
  task automatic t_polwin();
    wr(`PTR_CFG, 16'h0598);
    chk("config", 16'h8598, config_o);
    conv(16'h0050);
    pin(1'b1);
    conv(16'h0150);
    pin(1'b0);
    $display("test window done");
  endtask : t_polwin
  task automatic t_latch();
    logic [15:0] v;
    wr(`PTR_CFG, 16'h0584);
    conv(16'h0300);
    conv(16'h0150);
    pin(1'b0);
    rd(`PTR_CONV, v);
    chk("conversion", 16'h0150, v);
    pin(1'b1);
    $display("test latch done");
  endtask : t_latch
  task automatic t_ready();
    wr(`PTR_LOW, 16'h0000);
    wr(`PTR_HIGH, 16'h8000);
    wr(`PTR_CFG, 16'h0480);
    conv(16'h0123);
    pin(1'b0);
    repeat (8) @(posedge ref_clk_i);
    pin(1'b1);
    wr(`PTR_CFG, 16'h0580);
    conv_busy_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    pin(1'b0);
    conv_busy_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    pin(1'b1);
    chk("start pulse", 16'h0000, {15'h0, start_seen});
    wr(`PTR_CFG, 16'h8580);
    repeat (2) @(posedge ref_clk_i);
    chk("start pulse", 16'h0001, {15'h0, start_seen});
    $display("test ready done");
  endtask : t_ready
  task automatic t_addr();
    logic [15:0] v;
    logic [7:0] rx;
    logic ack;
    for (int s = 0; s < 4; s++) begin
      addr_sel_i <= 2'(s);
      repeat (4) @(posedge ref_clk_i);
      rd(`PTR_HIGH, v);
      chk("high limit", 16'h8000, v);
    end
    host_u.start_cond();
    host_u.xfer({`ADDR_BASE, 2'h0, 1'b0}, 1'b1, rx, ack);
    chk("foreign address ack", 16'h0000, {15'h0, ack});
    host_u.stop_cond();
    $display("test address done");
  endtask : t_addr
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (10) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    t_reset();
    t_queue();
    t_polwin();
    t_latch();
    t_ready();
    t_addr();
    complete_run();
  end
  initial begin
    repeat (90000) @(posedge ref_clk_i);
    fail_count++;
    complete_run();
  end
endmodule : adc_threshold_alert_logic_tb
